// >>> verilog/ctl_port_pkg.sv
// Purpose: shared constants and types of the paged serial control port
// Assumes: one 20 MHz core clock, bus pins sampled as plain inputs
// Notes:   register index is 7 bits, page select is 8 bits
package ctl_port_pkg;

    // core clock rate and bus clock budget
    localparam int          CLK_HZ            = 20000000;
    localparam int          FAST_SCL_HZ       = 400000;
    localparam int          SCL_CLKS          = CLK_HZ / FAST_SCL_HZ;

    // target address layout
    localparam logic [4:0]  ADDR_FIXED_BITS   = 5'h13;
    localparam int          ADDR_SEL_W        = 2;

    // register index and page select
    localparam int          INDEX_W           = 7;
    localparam int          PAGE_W            = 8;
    localparam logic [6:0]  PAGE_SELECT_INDEX = 7'h00;
    localparam logic [6:0]  INDEX_FIRST       = 7'h00;
    localparam logic [6:0]  INDEX_LAST        = 7'h7F;
    localparam logic [7:0]  PAGE_SELECT_RESET = 8'h00;
    localparam int          AUTO_INC_BIT      = 7;

    // byte framing
    localparam logic [3:0]  BITS_PER_BYTE     = 4'h8;
    localparam logic [3:0]  BIT_CNT_RESET     = 4'h0;
    localparam logic [7:0]  SHIFT_RESET       = 8'h00;
    localparam logic [2:0]  SYNC_IDLE         = 3'h7;
    localparam logic [1:0]  RST_SYNC_RESET    = 2'h0;

    // bus engine phases
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RACK
    } phase_t;

endpackage

// >>> verilog/reg_mem_if.sv
// Purpose: carrier between the bus engine and the register store
// Assumes: single clock, write and read in the same cycle allowed
// Notes:   read data lag the read address by one clock
`timescale 1ns/1ns
interface reg_mem_if #(
    parameter int ADDR_W = 9,
    parameter int DATA_W = 8
);
    logic              we;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [ADDR_W-1:0] raddr;
    logic [DATA_W-1:0] rdata;

    // engine side drives addresses and write data
    modport ctrl (
        output we,
        output waddr,
        output wdata,
        output raddr,
        input  rdata
    );

    // store side answers with registered read data
    modport mem (
        input  we,
        input  waddr,
        input  wdata,
        input  raddr,
        output rdata
    );
endinterface

// >>> verilog/reg_store.sv
// Purpose: paged register storage behind the control port
// Assumes: contents are not cleared by reset
// Notes:   read data come out of a register, one clock after the address
`timescale 1ns/1ns
module reg_store #(
    parameter int ADDR_W = 9,
    parameter int DATA_W = 8
) (
    input  wire logic clk,
    reg_mem_if.mem    port
);
    logic [DATA_W-1:0] mem_q [0:(1 << ADDR_W) - 1];
    logic [DATA_W-1:0] rdata_q;

    // storage write port
    always_ff @(posedge clk)
    begin
        if (port.we)
        begin
            mem_q[port.waddr] <= port.wdata;
        end
    end

    // registered read port
    always_ff @(posedge clk)
    begin
        rdata_q <= mem_q[port.raddr];
    end

    assign port.rdata = rdata_q;
endmodule

// >>> verilog/ctl_port.sv
// Purpose: target-only two-wire control port onto a paged register map
// Assumes: bus pins come from outside the clock domain; SCL not stretched
// Notes:   index 0 of every page is the page select; the rest is in reg_store
//
// How it works
// - target only, standard and fast speeds
// - index 0 on every page selects page
// - 7-bit address, first byte LSB is direction
// - upper five address bits fixed at 10011
// - low two address bits follow select pins
// - acknowledge only a matching target address
// - auto-increment allows multi-register block transfers
// - never initiate; receive on write, send on read
// - acknowledge address and every written byte
// - send read bytes until master not-acknowledges
// - index plus one per byte, 0x7F wraps
`timescale 1ns/1ns
module ctl_port
    import ctl_port_pkg::*;
#(
    parameter int PAGE_BITS = 2
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_n,
    input  wire logic              addr_select_low_pin,
    input  wire logic              addr_select_high_pin,
    output logic [PAGE_W-1:0]      active_page
);
    localparam int MEM_AW = PAGE_BITS + INDEX_W;

    // store address from page and index
    function automatic logic [MEM_AW-1:0] mem_addr(input logic [PAGE_W-1:0]  page,
                                                   input logic [INDEX_W-1:0] index);
        mem_addr = {page[PAGE_BITS-1:0], index};
    endfunction

    // index step with wrap from the last location
    function automatic logic [INDEX_W-1:0] next_index(input logic [INDEX_W-1:0] index);
        next_index = (index == INDEX_LAST) ? INDEX_FIRST : index + 7'h01;
    endfunction

    // accept a new level once the second and third stage agree
    function automatic logic filt(input logic [2:0] s, input logic prev);
        filt = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    logic [1:0]         rst_s_q;
    logic [1:0]         rst_s_d;
    logic               rst_n;

    logic [2:0]         scl_s_q;
    logic [2:0]         scl_s_d;
    logic [2:0]         sda_s_q;
    logic [2:0]         sda_s_d;
    logic [2:0]         sel_lo_s_q;
    logic [2:0]         sel_lo_s_d;
    logic [2:0]         sel_hi_s_q;
    logic [2:0]         sel_hi_s_d;
    logic               scl_f_q;
    logic               scl_f_d;
    logic               sda_f_q;
    logic               sda_f_d;
    logic [1:0]         sel_f_q;
    logic [1:0]         sel_f_d;
    logic               scl_p_q;
    logic               scl_p_d;
    logic               sda_p_q;
    logic               sda_p_d;

    logic               scl_rise;
    logic               scl_fall;
    logic               start_cond;
    logic               stop_cond;
    logic [6:0]         own_addr;
    logic [7:0]         rd_byte;

    phase_t             state_q;
    phase_t             state_d;
    logic [3:0]         cnt_q;
    logic [3:0]         cnt_d;
    logic [7:0]         shift_q;
    logic [7:0]         shift_d;
    logic               rw_q;
    logic               rw_d;
    logic               reg_phase_q;
    logic               reg_phase_d;
    logic               inc_q;
    logic               inc_d;
    logic               acked_q;
    logic               acked_d;
    logic [INDEX_W-1:0] index_q;
    logic [INDEX_W-1:0] index_d;
    logic [PAGE_W-1:0]  page_q;
    logic [PAGE_W-1:0]  page_d;
    logic               oe_n_q;
    logic               oe_n_d;
    logic               sda_out_q;
    logic               we_q;
    logic               we_d;
    logic [MEM_AW-1:0]  waddr_q;
    logic [MEM_AW-1:0]  waddr_d;
    logic [7:0]         wdata_q;
    logic [7:0]         wdata_d;

    reg_mem_if #(.ADDR_W(MEM_AW), .DATA_W(8)) mif ();

    // reset release through two stages
    always_comb
    begin
        rst_s_d = {rst_s_q[0], 1'b1};
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rst_s_q <= RST_SYNC_RESET;
        else
            rst_s_q <= rst_s_d;
    end

    assign rst_n = rst_s_q[1];

    // pin synchronisers, filtered levels and previous levels
    always_comb
    begin
        scl_s_d    = {scl_s_q[1:0], scl_in};
        sda_s_d    = {sda_s_q[1:0], sda_in};
        sel_lo_s_d = {sel_lo_s_q[1:0], addr_select_low_pin};
        sel_hi_s_d = {sel_hi_s_q[1:0], addr_select_high_pin};
        scl_f_d    = filt(scl_s_q, scl_f_q);
        sda_f_d    = filt(sda_s_q, sda_f_q);
        sel_f_d    = {filt(sel_hi_s_q, sel_f_q[1]), filt(sel_lo_s_q, sel_f_q[0])};
        scl_p_d    = scl_f_q;
        sda_p_d    = sda_f_q;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_s_q    <= SYNC_IDLE;
            sda_s_q    <= SYNC_IDLE;
            sel_lo_s_q <= SYNC_IDLE;
            sel_hi_s_q <= SYNC_IDLE;
            scl_f_q    <= 1'b1;
            sda_f_q    <= 1'b1;
            sel_f_q    <= 2'h0;
            scl_p_q    <= 1'b1;
            sda_p_q    <= 1'b1;
        end
        else
        begin
            scl_s_q    <= scl_s_d;
            sda_s_q    <= sda_s_d;
            sel_lo_s_q <= sel_lo_s_d;
            sel_hi_s_q <= sel_hi_s_d;
            scl_f_q    <= scl_f_d;
            sda_f_q    <= sda_f_d;
            sel_f_q    <= sel_f_d;
            scl_p_q    <= scl_p_d;
            sda_p_q    <= sda_p_d;
        end
    end

    // bus events; oversampled, so both speed grades work unchanged
    assign scl_rise   = scl_f_q & ~scl_p_q;
    assign scl_fall   = ~scl_f_q & scl_p_q;
    assign start_cond = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
    assign stop_cond  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

    // fixed upper bits plus the two select pins
    assign own_addr = {ADDR_FIXED_BITS, sel_f_q};

    // index 0 answers with the page select on every page
    assign rd_byte = (index_q == PAGE_SELECT_INDEX) ? page_q : mif.rdata;

    // store ports
    assign mif.we    = we_q;
    assign mif.waddr = waddr_q;
    assign mif.wdata = wdata_q;
    assign mif.raddr = mem_addr(page_q, index_q);

    // bus engine next state
    always_comb
    begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        shift_d     = shift_q;
        rw_d        = rw_q;
        reg_phase_d = reg_phase_q;
        inc_d       = inc_q;
        acked_d     = acked_q;
        index_d     = index_q;
        page_d      = page_q;
        oe_n_d      = oe_n_q;
        we_d        = 1'b0;
        waddr_d     = waddr_q;
        wdata_d     = wdata_q;
        if (start_cond)
        begin
            // start or repeated start always restarts address phase
            state_d = ST_ADDR;
            cnt_d   = BIT_CNT_RESET;
            oe_n_d  = 1'b1;
        end
        else if (stop_cond)
        begin
            state_d = ST_IDLE;
            oe_n_d  = 1'b1;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    oe_n_d = 1'b1;
                end
                ST_ADDR, ST_REG, ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_d = {shift_q[6:0], sda_f_q};
                        cnt_d   = cnt_q + 4'h1;
                    end
                    else if (scl_fall && cnt_q == BITS_PER_BYTE)
                    begin
                        cnt_d   = BIT_CNT_RESET;
                        oe_n_d  = 1'b0;
                        state_d = ST_ACK;
                        if (state_q == ST_ADDR)
                        begin
                            if (shift_q[7:1] == own_addr)
                            begin
                                rw_d        = shift_q[0];
                                reg_phase_d = ~shift_q[0];
                            end
                            else
                            begin
                                oe_n_d  = 1'b1;
                                state_d = ST_IDLE;
                            end
                        end
                        else if (state_q == ST_REG)
                        begin
                            inc_d       = shift_q[AUTO_INC_BIT];
                            index_d     = shift_q[6:0];
                            reg_phase_d = 1'b0;
                        end
                        else if (index_q == PAGE_SELECT_INDEX)
                        begin
                            page_d = shift_q;
                            if (inc_q)
                                index_d = next_index(index_q);
                        end
                        else
                        begin
                            we_d    = 1'b1;
                            waddr_d = mem_addr(page_q, index_q);
                            wdata_d = shift_q;
                            if (inc_q)
                                index_d = next_index(index_q);
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_d = BIT_CNT_RESET;
                        if (rw_q)
                        begin
                            shift_d = rd_byte;
                            oe_n_d  = rd_byte[7];
                            state_d = ST_RDATA;
                        end
                        else
                        begin
                            oe_n_d  = 1'b1;
                            state_d = reg_phase_q ? ST_REG : ST_WDATA;
                        end
                    end
                end
                ST_RDATA:
                begin
                    if (scl_rise)
                    begin
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (cnt_q == BITS_PER_BYTE)
                        begin
                            cnt_d   = BIT_CNT_RESET;
                            oe_n_d  = 1'b1;
                            state_d = ST_RACK;
                        end
                        else
                        begin
                            shift_d = {shift_q[6:0], 1'b0};
                            oe_n_d  = shift_q[6];
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        acked_d = ~sda_f_q;
                        if (!sda_f_q && inc_q)
                            index_d = next_index(index_q);
                    end
                    else if (scl_fall)
                    begin
                        if (acked_q)
                        begin
                            shift_d = rd_byte;
                            oe_n_d  = rd_byte[7];
                            state_d = ST_RDATA;
                        end
                        else
                        begin
                            oe_n_d  = 1'b1;
                            state_d = ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // bus engine registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q     <= ST_IDLE;
            cnt_q       <= BIT_CNT_RESET;
            shift_q     <= SHIFT_RESET;
            rw_q        <= 1'b0;
            reg_phase_q <= 1'b0;
            inc_q       <= 1'b0;
            acked_q     <= 1'b0;
            index_q     <= INDEX_FIRST;
            page_q      <= PAGE_SELECT_RESET;
            oe_n_q      <= 1'b1;
            sda_out_q   <= 1'b0;
            we_q        <= 1'b0;
            waddr_q     <= '0;
            wdata_q     <= SHIFT_RESET;
        end
        else
        begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            shift_q     <= shift_d;
            rw_q        <= rw_d;
            reg_phase_q <= reg_phase_d;
            inc_q       <= inc_d;
            acked_q     <= acked_d;
            index_q     <= index_d;
            page_q      <= page_d;
            oe_n_q      <= oe_n_d;
            sda_out_q   <= 1'b0;
            we_q        <= we_d;
            waddr_q     <= waddr_d;
            wdata_q     <= wdata_d;
        end
    end

    // paged register storage
    reg_store #(
        .ADDR_W (MEM_AW),
        .DATA_W (8)
    ) u_store (
        .clk  (clk),
        .port (mif.mem)
    );

    // open-drain data pin: only ever pulls low
    assign sda_out     = sda_out_q;
    assign sda_oe_n    = oe_n_q;
    assign active_page = page_q;
endmodule

// >>> dv/i2c_master_model.sv
// Purpose: behavioural bus master for the control port's two wires
// Assumes: open-drain data line with pull-up resolved by the bench
// Notes:   clock rests high between frames; bench calls the tasks
`timescale 1ns/1ns
module i2c_master_model #(
    parameter int HALF_NS = 400
) (
    input  wire logic sda,
    output logic      scl,
    output logic      master_oe_n
);
    initial
    begin
        scl = 1'b1;
        master_oe_n = 1'b1;
    end

    // one bit: data set in the low half, sampled in the high half
    task automatic bit_cycle(input logic b, output logic s);
        #(HALF_NS/2) master_oe_n = b;
        #(HALF_NS/2) scl = 1'b1;
        #(HALF_NS/2) s = sda;
        #(HALF_NS/2) scl = 1'b0;
    endtask

    // start or repeated start: data falls while clock high
    task automatic start_cond();
        if (scl === 1'b0)
        begin
            #(HALF_NS/2) master_oe_n = 1'b1;
            #(HALF_NS/2) scl = 1'b1;
        end
        #(HALF_NS/2) master_oe_n = 1'b0;
        #(HALF_NS/2) scl = 1'b0;
    endtask

    // stop: data rises while clock high, then bus rests
    task automatic stop_cond();
        #(HALF_NS/2) master_oe_n = 1'b0;
        #(HALF_NS/2) scl = 1'b1;
        #(HALF_NS/2) master_oe_n = 1'b1;
        #(HALF_NS);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(b[i], s);
        bit_cycle(1'b1, ack);
    endtask

    // acknowledge every byte but the last
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(last, s);
    endtask
endmodule

// >>> dv/ctl_port_checker.sv
// Purpose: concurrent checks on the control port pins
// Assumes: raw bus wires seen one clock late by a single flop
// Notes:   tracks only the first byte after each start
`timescale 1ns/1ns
module ctl_port_checker
    import ctl_port_pkg::*;
#(
    parameter int PAGE_BITS = 2
) (
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              scl_in,
    input wire logic              sda_in,
    input wire logic              sda_out,
    input wire logic              sda_oe_n,
    input wire logic              addr_select_low_pin,
    input wire logic              addr_select_high_pin,
    input wire logic [PAGE_W-1:0] active_page
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] cnt_q;
    logic [7:0] addr_q;
    logic       first_q;
    logic       ign_q;
    logic       match;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // own address as the pins select it
    assign match = addr_q[7:1] == {ADDR_FIXED_BITS, addr_select_high_pin, addr_select_low_pin};

    // first byte after a start, then ignore state for a foreign address
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            cnt_q <= 4'h0;
            addr_q <= 8'h00;
            first_q <= 1'b0;
            ign_q <= 1'b0;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            if (scl_q && scl_in && sda_q && !sda_in)
            begin
                cnt_q <= 4'h0;
                first_q <= 1'b1;
                ign_q <= 1'b0;
            end
            else if (!scl_q && scl_in && first_q)
            begin
                if (cnt_q == 4'h8)
                begin
                    first_q <= 1'b0;
                    ign_q <= !match;
                end
                else
                begin
                    cnt_q <= cnt_q + 4'h1;
                    addr_q <= {addr_q[6:0], sda_in};
                end
            end
        end
    end

    sequence ninth_rise;
        first_q && cnt_q == 4'h8 && !scl_q && scl_in;
    endsequence
    sequence idle_two;
        (sda_oe_n && active_page == 8'h00) [*2];
    endsequence

    sda_low_only_a: assert property (sda_out == 1'b0)
        else $error("data drive value not low");
    reset_idle_a: assert property ($rose(nrst) |-> idle_two)
        else $error("not idle right after reset");
    page_at_low_a: assert property ($changed(active_page) |-> !scl_in)
        else $error("page changed while bus clock high");
    oe_at_low_a: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data drive changed while bus clock high");
    addr_quiet_a: assert property (first_q && cnt_q < 4'h8 |-> sda_oe_n)
        else $error("data driven during address byte");
    ack_match_a: assert property (ninth_rise ##0 match |-> !sda_oe_n)
        else $error("own address not acknowledged");
    nack_other_a: assert property (first_q && cnt_q == 4'h8 && !match |-> sda_oe_n)
        else $error("foreign address acknowledged");
    ignore_rest_a: assert property (ign_q |-> sda_oe_n)
        else $error("drove data after foreign address");
endmodule

bind ctl_port ctl_port_checker #(.PAGE_BITS(PAGE_BITS)) chk (.*);

// >>> dv/test_paged_i2c_slave_control_port.sv
// Purpose: self-checking bench for the paged serial control port
// Assumes: one master model, pull-up on the data line
// Notes:   four store pages; random values from a fixed seed
`timescale 1ns/1ns
module test_paged_i2c_slave_control_port
    import ctl_port_pkg::*;
;
    logic       clk;
    logic       nrst;
    logic       sel_lo;
    logic       sel_hi;
    logic       sda_out;
    logic       sda_oe_n;
    logic [7:0] active_page;
    wire        scl;
    wire        master_oe_n;
    wire        sda;
    int         seed;
    int         mismatches;
    int         n_tests;
    int         cycles;
    logic       ack;
    logic [7:0] rd;
    logic [7:0] v[4];
    logic [7:0] wq[$];
    logic [7:0] rq[$];

    // resolved open-drain line with pull-up
    assign sda = (master_oe_n ? 1'b1 : 1'b0) & (sda_oe_n ? 1'b1 : sda_out);

    ctl_port #(.PAGE_BITS(2)) uut (
        .clk                  (clk),
        .nrst                 (nrst),
        .scl_in               (scl),
        .sda_in               (sda),
        .sda_out              (sda_out),
        .sda_oe_n             (sda_oe_n),
        .addr_select_low_pin  (sel_lo),
        .addr_select_high_pin (sel_hi),
        .active_page          (active_page)
    );
    i2c_master_model #(.HALF_NS(400)) mst (
        .sda         (sda),
        .scl         (scl),
        .master_oe_n (master_oe_n)
    );

    always #25 clk = ~clk;

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic [7:0] dev_byte(input logic dir);
        return {ADDR_FIXED_BITS, sel_hi, sel_lo, dir};
    endfunction

    // register byte then queued data, every byte acknowledged
    task automatic write_seq(input logic [7:0] regb);
        mst.start_cond();
        mst.send_byte(dev_byte(1'b0), ack);
        check({7'h00, ack}, 8'h00);
        mst.send_byte(regb, ack);
        check({7'h00, ack}, 8'h00);
        foreach (wq[i])
        begin
            mst.send_byte(wq[i], ack);
            check({7'h00, ack}, 8'h00);
        end
        mst.stop_cond();
        wq.delete();
    endtask

    // index first, then repeated start in the read direction
    task automatic read_seq(input logic [7:0] regb, input int n);
        mst.start_cond();
        mst.send_byte(dev_byte(1'b0), ack);
        mst.send_byte(regb, ack);
        mst.start_cond();
        mst.send_byte(dev_byte(1'b1), ack);
        check({7'h00, ack}, 8'h00);
        rq.delete();
        for (int i = 0; i < n; i++)
        begin
            mst.recv_byte(i == n - 1, rd);
            rq.push_back(rd);
        end
        mst.stop_cond();
        check({7'h00, sda_oe_n}, 8'h01);
    endtask

    task automatic set_page(input logic [7:0] pg);
        wq.push_back(pg);
        write_seq(8'h00);
        check(active_page, pg);
    endtask

    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        sel_lo = 1'b0;
        sel_hi = 1'b0;
        seed = 43;
        mismatches = 0;
        n_tests = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        check(active_page, 8'h00);
        check({7'h00, sda_oe_n}, 8'h01);
        $display("test reset done");
        // each select setting: own address answered, others ignored
        for (int p = 0; p < 4; p++)
        begin
            {sel_hi, sel_lo} = p[1:0];
            #400;
            mst.start_cond();
            mst.send_byte({5'h13, p[1:0], 1'b0}, ack);
            check({7'h00, ack}, 8'h00);
            mst.stop_cond();
            rd = 8'($random(seed));
            if (rd[7:3] == 5'h13)
                rd[7] = ~rd[7];
            for (int k = 0; k < 2; k++)
            begin
                mst.start_cond();
                mst.send_byte(k == 0 ? {5'h13, ~p[1:0], 1'b0} : rd, ack);
                check({7'h00, ack}, 8'h01);
                mst.send_byte(8'h00, ack);
                check({7'h00, ack}, 8'h01);
                mst.stop_cond();
            end
        end
        $display("test address done");
        rd = 8'($random(seed));
        {sel_hi, sel_lo} = rd[1:0];
        #400;
        // each page keeps its own cell at one index
        for (int p = 0; p < 4; p++)
        begin
            v[p] = 8'($random(seed));
            set_page(p[7:0]);
            wq.push_back(v[p]);
            write_seq(8'h10);
        end
        for (int p = 3; p >= 0; p--)
        begin
            set_page(p[7:0]);
            read_seq(8'h10, 1);
            check(rq[0], v[p]);
        end
        rd = 8'($random(seed));
        set_page(rd);
        read_seq(8'h00, 1);
        check(rq[0], rd);
        $display("test pages done");
        // increment across the top index lands on the page select
        set_page(8'h03);
        for (int i = 0; i < 3; i++)
        begin
            v[i] = 8'($random(seed));
            wq.push_back(v[i]);
        end
        write_seq(8'hFE);
        check(active_page, v[2]);
        set_page(8'h03);
        read_seq(8'hFE, 3);
        check(rq[0], v[0]);
        check(rq[1], v[1]);
        check(rq[2], 8'h03);
        $display("test wrap done");
        // increment off: every byte hits the same cell
        wq.push_back(v[0]);
        wq.push_back(v[1]);
        write_seq(8'h05);
        read_seq(8'h05, 2);
        check(rq[0], v[1]);
        check(rq[1], v[1]);
        $display("test fixed index done");
        end_of_test();
    end
endmodule
